/* File: clk_mode_pkg.sv */
// constants, field layout and types of the system clock mode block
// assumes one 50 MHz system clock and an 8-bit register port
//
// Summary of operation
// - with full speed off, codes 000 and 001 pick low clock; 111 picks high/2
// - other select codes pick the high clock divided by 4 up to 64
// - fast wake-up set: run on substitute clock after wake from idle0 or sleep1 (not deep sleep) until high clock stable
// - low-speed ready flag reads 0 while in deep sleep mode
// - low ready rises 128 edges after wake on crystal, 2 on RC
// - low ready also rises after power-on reset once the oscillator settled
// - full speed set selects the undivided high clock; clear lets select field decide
// - moving from high to low system clock stops the high oscillator
// - halt with idle select set enters idle instead of sleep
package clk_mode_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int         ADDR_W        = 4;
	localparam logic [3:0] ADDR_MODE     = 4'h0;
	localparam logic [3:0] ADDR_STATUS   = 4'h1;
	localparam logic [3:0] ADDR_ENABLE   = 4'h2;
	localparam logic [3:0] ADDR_CLEAR    = 4'h3;

	// ----------------------------------------------------------------
	// mode register fields
	// ----------------------------------------------------------------
	localparam int         BIT_FULL      = 0;
	localparam int         BIT_IDLE      = 1;
	localparam int         BIT_HIGH_RDY  = 2;
	localparam int         BIT_LOW_RDY   = 3;
	localparam int         BIT_FAST      = 4;
	localparam int         CKS_LSB       = 5;
	localparam int         CKS_W         = 3;
	localparam logic [7:0] MODE_RESET    = 8'h03;
	localparam logic [2:0] CKS_LOW_MAX   = 3'h1;

	// ----------------------------------------------------------------
	// event bits of status, enable and clear
	// ----------------------------------------------------------------
	localparam int         EV_W          = 3;
	localparam int         EV_LOW_RDY    = 0;
	localparam int         EV_HIGH_RDY   = 1;
	localparam int         EV_WAKE       = 2;

	// ----------------------------------------------------------------
	// oscillator settling counts, in oscillator edges
	// ----------------------------------------------------------------
	localparam int         CNT_W         = 8;
	localparam logic [7:0] LOW_XTAL_EDGES  = 8'h80;
	localparam logic [7:0] LOW_RC_EDGES    = 8'h02;
	localparam logic [7:0] HIGH_XTAL_EDGES = 8'h80;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_IDLE0,
		MODE_IDLE1,
		MODE_DEEP_SLEEP_MODE,
		MODE_SLEEP1,
		MODE_WAKING
	} power_mode_t;

	typedef enum logic [1:0] {
		SRC_HIGH,
		SRC_LOW,
		SRC_SUB,
		SRC_NONE
	} clk_src_t;

endpackage : clk_mode_pkg

/* File: osc_ready_timer.sv */
// oscillator settling timer: counts edges of a running oscillator
// assumes the edge pulse is already synchronised to sys_clk
`timescale 1ns/100ps
`default_nettype none

module osc_ready_timer #(
	parameter int COUNT_W = 8
) (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               reset,
	// oscillator status
	input  wire logic               run,
	input  wire logic               osc_edge,
	input  wire logic [COUNT_W-1:0] target,
	output logic                    ready
);

	logic [COUNT_W-1:0] count;
	logic [COUNT_W-1:0] next_count;

	if (COUNT_W < 2) begin : g_bad_width
		$error("osc_ready_timer: COUNT_W must be at least 2");
	end

	assign next_count = count + 1'b1;

	// ----------------------------------------------------------------
	// edge counter, cleared while the oscillator is stopped
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count <= '0;
			ready <= 1'b0;
		end else if (!run) begin
			count <= '0;
			ready <= 1'b0;
		end else if (osc_edge && !ready) begin
			count <= next_count;
			ready <= (next_count >= target);
		end
	end

endmodule : osc_ready_timer
`default_nettype wire

/* File: system_clock_mode_ctrl.sv */
// system clock mode register, clock source selection and halt mode control
// assumes oscillator pins and the crystal strap are asynchronous to sys_clk;
// halt, wake and peripheral-need inputs come from logic on sys_clk
`timescale 1ns/100ps
`default_nettype none

module system_clock_mode_ctrl (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      reset,
	// register port
	input  wire logic [clk_mode_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_write,
	input  wire logic                      reg_read,
	output logic      [7:0]                reg_rdata,
	// oscillator pins and strap
	input  wire logic                      high_osc_in,
	input  wire logic                      low_osc_in,
	input  wire logic                      low_speed_crystal,
	// cpu and halt entry
	input  wire logic                      halt_request,
	input  wire logic                      wake_event,
	input  wire logic                      idle_clock_keep_on,
	input  wire logic                      sub_clock_needed,
	// clock control outputs
	output var clk_mode_pkg::clk_src_t     clock_source,
	output logic      [2:0]                high_divide_log2,
	output logic                           high_osc_enable,
	output logic                           low_osc_enable,
	output logic                           cpu_clock_run,
	output logic                           periph_clock_run,
	output var clk_mode_pkg::power_mode_t  power_mode,
	// interrupt
	output logic                           irq
);
	import clk_mode_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers and edge detect
	// ----------------------------------------------------------------
	logic [2:0] pin_raw;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic [2:0] pin_prev;
	logic       high_edge;
	logic       low_edge;
	logic       crystal_sel;

	assign pin_raw = {low_speed_crystal, low_osc_in, high_osc_in};

	for (genvar i = 0; i < 3; i++) begin : g_sync
		always_ff @(posedge sys_clk or posedge reset) begin
			if (reset) begin
				pin_meta[i] <= 1'b0;
				pin_sync[i] <= 1'b0;
				pin_prev[i] <= 1'b0;
			end else begin
				pin_meta[i] <= pin_raw[i];
				pin_sync[i] <= pin_meta[i];
				pin_prev[i] <= pin_sync[i];
			end
		end
	end

	assign high_edge   = pin_sync[0] & ~pin_prev[0];
	assign low_edge    = pin_sync[1] & ~pin_prev[1];
	assign crystal_sel = pin_sync[2];

	// ----------------------------------------------------------------
	// mode register
	// ----------------------------------------------------------------
	logic [CKS_W-1:0] clock_source_select;
	logic             fast_wakeup_enable;
	logic             idle_on_halt_select;
	logic             full_speed_select;
	logic             mode_write;
	logic             uses_high;

	assign mode_write = reg_write && (reg_addr == ADDR_MODE);

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			clock_source_select <= MODE_RESET[CKS_LSB +: CKS_W];
			fast_wakeup_enable  <= MODE_RESET[BIT_FAST];
			idle_on_halt_select <= MODE_RESET[BIT_IDLE];
			full_speed_select   <= MODE_RESET[BIT_FULL];
		end else if (mode_write) begin
			clock_source_select <= reg_wdata[CKS_LSB +: CKS_W];
			fast_wakeup_enable  <= reg_wdata[BIT_FAST];
			idle_on_halt_select <= reg_wdata[BIT_IDLE];
			full_speed_select   <= reg_wdata[BIT_FULL];
		end
	end

	assign uses_high = full_speed_select || (clock_source_select > CKS_LOW_MAX);

	// ----------------------------------------------------------------
	// oscillator ready timers
	// ----------------------------------------------------------------
	logic       low_timer_ready;
	logic       high_ready;
	logic       low_ready;
	logic [7:0] low_target;

	assign low_target = crystal_sel ? LOW_XTAL_EDGES : LOW_RC_EDGES;

	osc_ready_timer #(
		.COUNT_W (CNT_W)
	) u_low_timer (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.run      (low_osc_enable),
		.osc_edge (low_edge),
		.target   (low_target),
		.ready    (low_timer_ready)
	);

	osc_ready_timer #(
		.COUNT_W (CNT_W)
	) u_high_timer (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.run      (high_osc_enable),
		.osc_edge (high_edge),
		.target   (HIGH_XTAL_EDGES),
		.ready    (high_ready)
	);

	assign low_ready = low_timer_ready && (power_mode != MODE_DEEP_SLEEP_MODE);

	// ----------------------------------------------------------------
	// power mode state machine
	// ----------------------------------------------------------------
	logic from_deep_sleep_mode;
	logic target_ready;
	logic fast_path;
	logic wake_taken;

	assign target_ready = uses_high ? high_ready : low_ready;
	assign fast_path    = (power_mode == MODE_WAKING) && fast_wakeup_enable && !from_deep_sleep_mode
		&& uses_high && !high_ready && low_ready;
	assign wake_taken   = wake_event && (power_mode inside {MODE_IDLE0, MODE_IDLE1,
		MODE_DEEP_SLEEP_MODE, MODE_SLEEP1});

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			power_mode  <= MODE_RUN;
			from_deep_sleep_mode <= 1'b0;
		end else begin
			unique case (power_mode)
				MODE_RUN: begin
					if (halt_request) begin
						if (idle_on_halt_select) begin
							power_mode <= idle_clock_keep_on ? MODE_IDLE1 : MODE_IDLE0;
						end else begin
							power_mode <= sub_clock_needed ? MODE_SLEEP1 : MODE_DEEP_SLEEP_MODE;
						end
					end
				end
				MODE_IDLE1: begin
					if (wake_event) begin
						power_mode <= MODE_RUN;
					end
				end
				MODE_IDLE0, MODE_SLEEP1: begin
					if (wake_event) begin
						power_mode  <= MODE_WAKING;
						from_deep_sleep_mode <= 1'b0;
					end
				end
				MODE_DEEP_SLEEP_MODE: begin
					if (wake_event) begin
						power_mode  <= MODE_WAKING;
						from_deep_sleep_mode <= 1'b1;
					end
				end
				MODE_WAKING: begin
					if (target_ready) begin
						power_mode <= MODE_RUN;
					end
				end
				default: begin
					power_mode <= MODE_RUN;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// clock source and oscillator enables
	// ----------------------------------------------------------------
	clk_src_t   next_source;
	logic [2:0] next_divide;

	always_comb begin
		next_source = SRC_NONE;
		if (power_mode inside {MODE_RUN, MODE_IDLE1}) begin
			next_source = (uses_high && high_ready) ? SRC_HIGH : SRC_LOW;
		end else if (fast_path) begin
			next_source = SRC_SUB;
		end
		next_divide = 3'h0;
		if (next_source == SRC_HIGH && !full_speed_select) begin
			next_divide = 3'h0 - clock_source_select;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			clock_source     <= SRC_LOW;
			high_divide_log2 <= 3'h0;
			high_osc_enable  <= 1'b0;
			low_osc_enable   <= 1'b0;
			cpu_clock_run    <= 1'b0;
			periph_clock_run <= 1'b0;
		end else begin
			clock_source     <= next_source;
			high_divide_log2 <= next_divide;
			high_osc_enable  <= uses_high && (power_mode inside {MODE_RUN, MODE_IDLE1,
				MODE_WAKING});
			low_osc_enable   <= (power_mode != MODE_DEEP_SLEEP_MODE);
			cpu_clock_run    <= (power_mode == MODE_RUN) || fast_path;
			periph_clock_run <= (power_mode inside {MODE_RUN, MODE_IDLE1}) || fast_path;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status, enable and clear
	// ----------------------------------------------------------------
	logic [EV_W-1:0] irq_status;
	logic [EV_W-1:0] irq_enable;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] clear_bits;
	logic            low_ready_prev;
	logic            high_ready_prev;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			low_ready_prev  <= 1'b0;
			high_ready_prev <= 1'b0;
		end else begin
			low_ready_prev  <= low_ready;
			high_ready_prev <= high_ready;
		end
	end

	always_comb begin
		events              = '0;
		events[EV_LOW_RDY]  = low_ready && !low_ready_prev;
		events[EV_HIGH_RDY] = high_ready && !high_ready_prev;
		events[EV_WAKE]     = wake_taken;
		clear_bits          = (reg_write && reg_addr == ADDR_CLEAR) ? reg_wdata[EV_W-1:0] : '0;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~clear_bits) | events;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq_enable <= '0;
		end else if (reg_write && reg_addr == ADDR_ENABLE) begin
			irq_enable <= reg_wdata[EV_W-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_enable);
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			unique case (reg_addr)
				ADDR_MODE:   reg_rdata <= {clock_source_select, fast_wakeup_enable, low_ready,
					high_ready, idle_on_halt_select, full_speed_select};
				ADDR_STATUS: reg_rdata <= {5'h00, irq_status};
				ADDR_ENABLE: reg_rdata <= {5'h00, irq_enable};
				default:     reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	chk_low_code_source: assert property (
		(power_mode == MODE_RUN && !full_speed_select && clock_source_select <= CKS_LOW_MAX)
		|=> clock_source == SRC_LOW)
		else $error("low select code did not pick the low clock");

	chk_divide_ratio: assert property (
		(next_source == SRC_HIGH && !full_speed_select)
		|=> high_divide_log2 == 3'(4'h8 - {1'b0, $past(clock_source_select)})
		&& high_divide_log2 != 3'h0)
		else $error("divided high clock ratio wrong");

	chk_fast_wake_sub: assert property (
		fast_path |=> clock_source == SRC_SUB && cpu_clock_run)
		else $error("fast wake-up did not run on substitute clock");

	chk_deep_sleep_mode_low_flag: assert property (
		(power_mode == MODE_DEEP_SLEEP_MODE && reg_read && reg_addr == ADDR_MODE)
		|=> !reg_rdata[BIT_LOW_RDY])
		else $error("low ready flag set in deep sleep");

	chk_low_ready_edge: assert property (
		$rose(low_timer_ready) |-> $past(low_edge) && $past(low_osc_enable))
		else $error("low ready rose without an oscillator edge");

	chk_full_speed_src: assert property (
		(power_mode == MODE_RUN && full_speed_select && high_ready)
		|=> clock_source == SRC_HIGH && high_divide_log2 == 3'h0)
		else $error("full speed did not pick undivided high clock");

	chk_high_osc_stop: assert property (
		(power_mode == MODE_RUN && !uses_high) |=> !high_osc_enable ##1 !high_ready)
		else $error("high oscillator kept on with low clock selected");

	chk_halt_idle: assert property (
		(power_mode == MODE_RUN && halt_request && idle_on_halt_select)
		|=> power_mode inside {MODE_IDLE0, MODE_IDLE1} ##1 !cpu_clock_run)
		else $error("halt with idle select did not enter idle");

	chk_ready_read: assert property (
		(reg_read && reg_addr == ADDR_MODE)
		|=> reg_rdata[BIT_LOW_RDY] == $past(low_ready)
		&& reg_rdata[BIT_HIGH_RDY] == $past(high_ready))
		else $error("ready flags do not show hardware status");

	chk_wake_sticky: assert property (
		(wake_taken && !(reg_write && reg_addr == ADDR_CLEAR && reg_wdata[EV_WAKE]))
		|=> irq_status[EV_WAKE] ##1 (irq || !$past(irq_enable[EV_WAKE])))
		else $error("wake event not kept in status");

endmodule : system_clock_mode_ctrl
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the system clock mode controller
// assumes the clk_mode_pkg package is compiled first; oscillators are made here
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import clk_mode_pkg::*;

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic              sys_clk;
	logic              reset;
	logic [3:0]        reg_addr;
	logic [7:0]        reg_wdata;
	logic              reg_write;
	logic              reg_read;
	logic [7:0]        reg_rdata;
	logic              high_osc_in;
	logic              low_osc_in;
	logic              low_speed_crystal;
	logic              halt_request;
	logic              wake_event;
	logic              idle_clock_keep_on;
	logic              sub_clock_needed;
	clk_src_t          clock_source;
	logic [2:0]        high_divide_log2;
	logic              high_osc_enable;
	logic              low_osc_enable;
	logic              cpu_clock_run;
	logic              periph_clock_run;
	power_mode_t       power_mode;
	logic              irq;
	logic [3:0]        osc_cnt = 4'h0;
	int                n_errors;
	int                n_tests;
	logic [7:0]        d;

	system_clock_mode_ctrl u_system_clock_mode_ctrl (
		.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.high_osc_in(high_osc_in), .low_osc_in(low_osc_in),
		.low_speed_crystal(low_speed_crystal), .halt_request(halt_request),
		.wake_event(wake_event), .idle_clock_keep_on(idle_clock_keep_on),
		.sub_clock_needed(sub_clock_needed), .clock_source(clock_source),
		.high_divide_log2(high_divide_log2), .high_osc_enable(high_osc_enable),
		.low_osc_enable(low_osc_enable), .cpu_clock_run(cpu_clock_run),
		.periph_clock_run(periph_clock_run), .power_mode(power_mode), .irq(irq)
	);

	// ----------------------------------------------------------------
	// clock and oscillators: high period 4 cycles, low period 16 cycles
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		osc_cnt     <= osc_cnt + 4'h1;
		high_osc_in <= osc_cnt[1] & high_osc_enable;
		low_osc_in  <= osc_cnt[3] & low_osc_enable;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic hang(input string msg);
		n_errors++;
		$display("[FAIL] %0t wait ran out: %s", $time, msg);
		summarize();
	endtask : hang

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	task automatic pulse(input logic is_wake);
		@(posedge sys_clk);
		halt_request <= ~is_wake;
		wake_event   <= is_wake;
		@(posedge sys_clk);
		halt_request <= 1'b0;
		wake_event   <= 1'b0;
		#1;
	endtask : pulse

	task automatic wait_src(input clk_src_t s, input int bound);
		int i;
		for (i = 0; i < bound && clock_source !== s; i++) tick(1);
		if (i == bound) hang("clock source");
	endtask : wait_src

	task automatic wait_rdy(input int bound);
		logic [7:0] v;
		int         i;
		v = 8'h00;
		for (i = 0; i < bound && v[BIT_LOW_RDY] !== 1'b1; i++) rd(ADDR_MODE, v);
		if (i == bound) hang("low ready");
	endtask : wait_rdy

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd(ADDR_MODE, d);
		chk(d, MODE_RESET, "mode reset value");
		tick(1);
		chk(reg_rdata, 8'h00, "read data lasts one cycle");
		chk(8'(clock_source), 8'(SRC_LOW), "source before high ready");
		chk(8'(power_mode), 8'(MODE_RUN), "mode after reset");
	endtask : t_reset

	task automatic t_power_on;
		wait_rdy(100);
		wait_src(SRC_HIGH, 1000);
		chk(8'(high_divide_log2), 8'h00, "full speed undivided");
		rd(ADDR_STATUS, d);
		chk(d, 8'h03, "ready events");
		wr(ADDR_MODE, 8'h01);
		rd(ADDR_MODE, d);
		chk(d, 8'h0d, "ready bits kept on write");
	endtask : t_power_on

	task automatic t_select;
		for (int i = 7; i >= 0; i--) begin
			wr(ADDR_MODE, {3'(i), 5'h00});
			tick(4);
			if (i >= 2) begin
				chk(8'(clock_source), 8'(SRC_HIGH), "divided source");
				chk(8'(high_divide_log2), 8'(8 - i), "divide ratio");
			end else begin
				chk(8'(clock_source), 8'(SRC_LOW), "low source");
				chk(8'(high_osc_enable), 8'h00, "high oscillator stopped");
			end
		end
		wr(ADDR_MODE, 8'h03);
		wait_src(SRC_HIGH, 1000);
	endtask : t_select

	task automatic t_irq;
		wr(ADDR_ENABLE, 8'h00);
		tick(2);
		chk(8'(irq), 8'h00, "masked irq");
		wr(ADDR_ENABLE, 8'h02);
		tick(2);
		chk(8'(irq), 8'h01, "enabled irq");
		rd(ADDR_ENABLE, d);
		chk(d, 8'h02, "enable readback");
		wr(ADDR_STATUS, 8'h00);
		rd(ADDR_STATUS, d);
		chk(d, 8'h03, "status is read only");
		wr(ADDR_CLEAR, 8'h02);
		tick(2);
		chk(8'(irq), 8'h00, "irq after clear");
		rd(ADDR_STATUS, d);
		chk(d, 8'h01, "status after clear");
		rd(ADDR_CLEAR, d);
		chk(d, 8'h00, "clear reads zero");
		rd(4'h9, d);
		chk(d, 8'h00, "unmapped read");
		wr(ADDR_CLEAR, 8'h07);
		wr(ADDR_ENABLE, 8'h04);
	endtask : t_irq

	task automatic t_deep_sleep_mode;
		@(posedge sys_clk);
		low_speed_crystal <= 1'b1;
		wr(ADDR_MODE, 8'h01);
		pulse(1'b0);
		tick(2);
		chk(8'(power_mode), 8'(MODE_DEEP_SLEEP_MODE), "halt without idle");
		chk({cpu_clock_run, low_osc_enable, high_osc_enable}, 8'h00, "clocks stopped");
		chk(8'(clock_source), 8'(SRC_NONE), "no source in sleep");
		rd(ADDR_MODE, d);
		chk(8'(d[BIT_LOW_RDY]), 8'h00, "low ready in sleep");
		pulse(1'b1);
		tick(1900);
		rd(ADDR_MODE, d);
		chk(8'(d[BIT_LOW_RDY]), 8'h00, "crystal ready too early");
		wait_rdy(200);
		chk(8'(irq), 8'h01, "wake event irq");
		wait_src(SRC_HIGH, 1000);
		chk(8'(power_mode), 8'(MODE_RUN), "run after wake");
	endtask : t_deep_sleep_mode

	task automatic t_idle;
		wr(ADDR_MODE, 8'h03);
		@(posedge sys_clk);
		idle_clock_keep_on <= 1'b1;
		pulse(1'b0);
		tick(2);
		chk(8'(power_mode), 8'(MODE_IDLE1), "halt with idle");
		chk({cpu_clock_run, periph_clock_run}, 8'h01, "idle1 clocks");
		pulse(1'b1);
		tick(2);
		chk(8'(power_mode), 8'(MODE_RUN), "idle1 wake");
	endtask : t_idle

	task automatic t_fast(input logic in_sleep1);
		wr(ADDR_MODE, in_sleep1 ? 8'h11 : 8'h13);
		@(posedge sys_clk);
		idle_clock_keep_on <= 1'b0;
		sub_clock_needed   <= in_sleep1;
		pulse(1'b0);
		tick(5);
		chk(8'(power_mode), in_sleep1 ? 8'(MODE_SLEEP1) : 8'(MODE_IDLE0), "halt entry");
		chk(8'(low_osc_enable), 8'h01, "substitute clock kept");
		pulse(1'b1);
		tick(3);
		chk(8'(clock_source), 8'(SRC_SUB), "substitute clock after wake");
		chk(8'(cpu_clock_run), 8'h01, "cpu runs on substitute");
		wait_src(SRC_HIGH, 1000);
		chk(8'(power_mode), 8'(MODE_RUN), "run after fast wake");
	endtask : t_fast

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		n_errors = 0;
		n_tests = 0;
		reset = 1'b1;
		{reg_addr, reg_wdata, reg_write, reg_read} = 14'h0000;
		{low_speed_crystal, halt_request, wake_event} = 3'h0;
		{idle_clock_keep_on, sub_clock_needed} = 2'h0;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		t_reset();
		t_power_on();
		t_select();
		t_irq();
		t_deep_sleep_mode();
		t_idle();
		t_fast(1'b0);
		t_fast(1'b1);
		summarize();
	end

endmodule : testbench

`default_nettype wire
